/* File: rtl/clvcp_params.svh */
`ifndef CLVCP_PARAMS_SVH
`define CLVCP_PARAMS_SVH

// Timing base
`define CLVCP_CLK_MHZ   10
`define CLVCP_MS_US     1000
`define CLVCP_DT_MS     3'h5
`define CLVCP_NPER      6
`define CLVCP_NTYPE     6

// Loop constants
`define CLVCP_P_GAIN    16'h07D0
`define CLVCP_DIV_STEPS 6'h28

// Coil drive frequency window and reset value
`define CLVCP_FMIN_HZ   16'h0028
`define CLVCP_FMAX_HZ   16'h0190
`define CLVCP_FRST_HZ   16'h0096

// Feedback input types
`define CLVCP_T_V5      3'h0
`define CLVCP_T_V10     3'h1
`define CLVCP_T_MA20    3'h2
`define CLVCP_T_OHM     3'h3
`define CLVCP_T_PWM     3'h4
`define CLVCP_T_FREQ    3'h5

// Input bias choices
`define CLVCP_BIAS_UP   2'h0
`define CLVCP_BIAS_CTR  2'h1
`define CLVCP_BIAS_DN   2'h2

`endif

/* File: rtl/clvcp_pkg.sv */
`default_nettype none
`include "clvcp_params.svh"

package clvcp_pkg;

   typedef logic signed [39:0] clvcp_wide_t;

   typedef struct packed {
      logic [15:0] dur_ms;
      logic [15:0] level_ma;
   } clvcp_period_s;

   typedef clvcp_period_s [`CLVCP_NPER-1:0] clvcp_prof_t;

   typedef struct packed {
      logic [2:0]  in_type;
      logic [1:0]  bias;
      logic [15:0] max_lim;
      logic [15:0] min_lim;
      logic [15:0] err_ms;
   } clvcp_lim_s;

   typedef struct packed {
      logic [15:0] target_value;
      logic [15:0] band;
      logic [15:0] int_ms;
      logic [15:0] der_ms;
      logic [15:0] windup_ma;
      logic [15:0] integral_freeze_threshold;
   } clvcp_pid_s;

   typedef enum logic [2:0] {
      ST_START, ST_PROF, ST_RAMP, ST_WAIT, ST_DP, ST_DI, ST_DD, ST_SUM
   } clvcp_state_e;

endpackage : clvcp_pkg

`default_nettype wire

/* File: rtl/clvcp_div.sv */
`timescale 1ns/100ps
`default_nettype none
`include "clvcp_params.svh"

module clvcp_div
   import clvcp_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire clvcp_wide_t dividend_i,
   input  wire logic [15:0] divisor_i,
   output var  logic        done_o,
   output var  clvcp_wide_t quot_o
);

   // Restoring divider, one quotient bit per clock
   logic [39:0] num_reg;
   logic [16:0] rem_reg;
   logic [15:0] dsr_reg;
   logic        neg_reg;
   logic        run_reg;
   logic [5:0]  cnt_reg;

   wire logic [16:0] shf   = {rem_reg[15:0], num_reg[39]};
   wire logic        fit   = shf >= {1'b0, dsr_reg};
   wire logic [16:0] rem_n = fit ? shf - {1'b0, dsr_reg} : shf;
   wire logic [39:0] mag   = dividend_i[39] ? 40'(-dividend_i) : 40'(dividend_i);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         num_reg <= 40'h00_0000_0000;
         rem_reg <= 17'h0_0000;
         dsr_reg <= 16'h0000;
         neg_reg <= 1'b0;
         run_reg <= 1'b0;
         cnt_reg <= 6'h00;
         done_o  <= 1'b0;
      end else begin
         done_o <= run_reg && cnt_reg == 6'h01;
         if (start_i) begin
            num_reg <= mag;
            rem_reg <= 17'h0_0000;
            dsr_reg <= divisor_i;
            neg_reg <= dividend_i[39];
            run_reg <= 1'b1;
            cnt_reg <= `CLVCP_DIV_STEPS;
         end else if (run_reg) begin
            num_reg <= {num_reg[38:0], fit};
            rem_reg <= rem_n;
            cnt_reg <= cnt_reg - 6'h01;
            run_reg <= cnt_reg != 6'h01;
         end
      end
   end

   // Divisor of zero yields junk; callers gate it
   assign quot_o = neg_reg ? clvcp_wide_t'(-num_reg) : clvcp_wide_t'(num_reg);

endmodule : clvcp_div

`default_nettype wire

/* File: rtl/clvcp_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "clvcp_params.svh"

// Notes on behaviour
// [RULE1] Feedback above maximum for the error time latches an input fault.
// [RULE2] Feedback below minimum for the error time faults, only after startup.
// [RULE3] Violations that recover inside the error time leave no fault.
// [RULE4] Input type picks one of six feedback sources.
// [RULE5] Pull-up or pull-down bias acts only for pulse-width and frequency inputs.
// [RULE6] After reset the current timing profile runs before regulation.
// [RULE7] All period durations zero skips straight to regulation.
// [RULE8] Six ordered periods, each driving its level for its duration.
// [RULE9] A level change ramps linearly across the new period.
// [RULE10] Profile end hands the output to the loop.
// [RULE11] Error is target minus measured feedback, signed.
// [RULE12] Proportional term is 2000 times error over band; band zero gives zero.
// [RULE13] Every 5 ms integral adds error times 5 over integral time.
// [RULE14] Derivative uses error change and previous term; zero time gives zero.
// [RULE15] Integral stops accumulating once output reaches the windup guard.
// [RULE16] Output is term sum clamped between zero and windup guard.
// [RULE17] Integral freezes while absolute error is below the hold threshold.
// [RULE18] Drive frequency accepted only between 40 and 400 Hz.
// [RULE19] Windup guard should be set at or below 3000 mA by the user.
// [RULE20] An input fault forces coil current to zero until reset.
module clvcp_top
   import clvcp_pkg::*;
#(
   parameter int MS_CYCLES = `CLVCP_MS_US * `CLVCP_CLK_MHZ
)(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] measured_value_i,
   input  wire clvcp_lim_s  lim_i,
   input  wire clvcp_pid_s  pid_i,
   input  wire clvcp_prof_t prof_i,
   input  wire logic [15:0] out_freq_i,
   output var  logic [15:0] coil_ma_o,
   output var  logic        fault_o,
   output var  logic        pid_active_o,
   output var  logic [15:0] freq_hz_o,
   output var  logic        freq_rej_o,
   output var  logic [5:0]  src_en_o,
   output var  logic        pull_up_o,
   output var  logic        pull_down_o
);

   // Feedback arrives from the sensor domain; word may tear for a cycle
   logic [15:0]  meas_s1_reg;
   logic [15:0]  meas_reg;
   logic [15:0]  ms_cnt_reg;
   logic         ms_tick_reg;
   logic [2:0]   dt_cnt_reg;
   logic [15:0]  hi_cnt_reg;
   logic [15:0]  lo_cnt_reg;
   logic         fault_reg;
   clvcp_state_e state_reg;
   logic [2:0]   idx_reg;
   logic [15:0]  elap_reg;
   logic [15:0]  prev_reg;
   logic [15:0]  drive_reg;
   logic signed [16:0] e_reg;
   logic signed [16:0] eprev_reg;
   clvcp_wide_t  p_reg;
   clvcp_wide_t  i_reg;
   clvcp_wide_t  d_reg;
   logic         div_go_reg;
   clvcp_wide_t  div_num_reg;
   logic [15:0]  div_den_reg;
   logic         div_done;
   clvcp_wide_t  div_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meas_s1_reg <= 16'h0000;
         meas_reg    <= 16'h0000;
      end else begin
         meas_s1_reg <= measured_value_i;
         meas_reg    <= meas_s1_reg;
      end
   end

   // Millisecond and loop-period ticks
   wire logic ms_wrap = ms_cnt_reg == 16'(MS_CYCLES - 1);
   wire logic dt_tick = ms_tick_reg && dt_cnt_reg == `CLVCP_DT_MS - 3'h1;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_cnt_reg  <= 16'h0000;
         ms_tick_reg <= 1'b0;
         dt_cnt_reg  <= 3'h0;
      end else begin
         ms_cnt_reg  <= ms_wrap ? 16'h0000 : ms_cnt_reg + 16'h0001;
         ms_tick_reg <= ms_wrap;
         if (ms_tick_reg) begin
            dt_cnt_reg <= dt_tick ? 3'h0 : dt_cnt_reg + 3'h1;
         end
      end
   end

   // Input supervision
   wire logic above  = meas_reg > lim_i.max_lim;
   wire logic below  = meas_reg < lim_i.min_lim && pid_active_o;
   wire logic hi_trip = above && hi_cnt_reg >= lim_i.err_ms;
   wire logic lo_trip = below && lo_cnt_reg >= lim_i.err_ms;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_cnt_reg <= 16'h0000;
         lo_cnt_reg <= 16'h0000;
         fault_reg  <= 1'b0;
      end else begin
         if (!above) begin
            hi_cnt_reg <= 16'h0000; // see [RULE3]
         end else if (ms_tick_reg && hi_cnt_reg != 16'hFFFF) begin
            hi_cnt_reg <= hi_cnt_reg + 16'h0001;
         end
         if (!below) begin
            lo_cnt_reg <= 16'h0000; // see [RULE2]
         end else if (ms_tick_reg && lo_cnt_reg != 16'hFFFF) begin
            lo_cnt_reg <= lo_cnt_reg + 16'h0001;
         end
         fault_reg <= fault_reg || hi_trip || lo_trip; // see [RULE1] see [RULE2]
      end
   end

   // Source select and bias
   logic [5:0] src_w;
   logic [`CLVCP_NPER-1:0] dz_w;
   genvar gi;
   for (gi = 0; gi < `CLVCP_NTYPE; gi++) begin : g_src
      assign src_w[gi] = lim_i.in_type == 3'(gi); // see [RULE4]
   end
   for (gi = 0; gi < `CLVCP_NPER; gi++) begin : g_dz
      assign dz_w[gi] = prof_i[gi].dur_ms == 16'h0000;
   end
   wire logic digi_in  = lim_i.in_type == `CLVCP_T_PWM || lim_i.in_type == `CLVCP_T_FREQ;
   wire logic bias_up  = digi_in && lim_i.bias == `CLVCP_BIAS_UP; // see [RULE5]
   wire logic bias_dn  = digi_in && lim_i.bias == `CLVCP_BIAS_DN;
   wire logic freq_ok  = out_freq_i >= `CLVCP_FMIN_HZ && out_freq_i <= `CLVCP_FMAX_HZ;
   wire logic all_zero = &dz_w;

   // Profile arithmetic
   wire clvcp_period_s cur = prof_i[idx_reg];
   wire logic [15:0] elap_next = elap_reg + 16'h0001;
   wire logic signed [16:0] lvl_diff = $signed({1'b0, cur.level_ma}) - $signed({1'b0, prev_reg});
   wire clvcp_wide_t ramp_num = clvcp_wide_t'(lvl_diff) * clvcp_wide_t'({1'b0, elap_next});
   wire logic per_end = cur.dur_ms == 16'h0000 || (ms_tick_reg && elap_next >= cur.dur_ms);
   wire logic last_per = idx_reg == 3'(`CLVCP_NPER - 1);

   // Loop arithmetic
   wire logic signed [16:0] err = $signed({1'b0, pid_i.target_value}) - $signed({1'b0, meas_reg});
   wire logic [16:0] abs_e  = e_reg[16] ? 17'(-e_reg) : 17'(e_reg);
   wire logic hold   = abs_e < {1'b0, pid_i.integral_freeze_threshold};
   wire logic wound  = drive_reg >= pid_i.windup_ma;
   wire logic signed [17:0] de = 18'(e_reg) - 18'(eprev_reg);
   wire clvcp_wide_t pid_sum = p_reg + i_reg + d_reg;
   wire clvcp_wide_t wind_w  = clvcp_wide_t'(pid_i.windup_ma);
   wire logic [15:0] pid_sat = pid_sum[39] ? 16'h0000 : (pid_sum > wind_w ? pid_i.windup_ma : pid_sum[15:0]);

   clvcp_div u_div (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .start_i    (div_go_reg),
      .dividend_i (div_num_reg),
      .divisor_i  (div_den_reg),
      .done_o     (div_done),
      .quot_o     (div_q)
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg    <= ST_START;
         idx_reg      <= 3'h0;
         elap_reg     <= 16'h0000;
         prev_reg     <= 16'h0000;
         drive_reg    <= 16'h0000;
         pid_active_o <= 1'b0;
         e_reg        <= 17'h0_0000;
         eprev_reg    <= 17'h0_0000;
         p_reg        <= 40'h00_0000_0000;
         i_reg        <= 40'h00_0000_0000;
         d_reg        <= 40'h00_0000_0000;
         div_go_reg   <= 1'b0;
         div_num_reg  <= 40'h00_0000_0000;
         div_den_reg  <= 16'h0000;
      end else begin
         div_go_reg <= 1'b0;
         case (state_reg)
            ST_START: begin
               prev_reg  <= prof_i[0].level_ma;
               drive_reg <= prof_i[0].level_ma;
               if (all_zero) begin
                  pid_active_o <= 1'b1; // see [RULE7]
                  state_reg    <= ST_WAIT;
               end else begin
                  state_reg <= ST_PROF; // see [RULE6]
               end
            end
            ST_PROF: begin
               if (per_end) begin
                  drive_reg <= cur.level_ma; // see [RULE8]
                  prev_reg  <= cur.level_ma;
                  elap_reg  <= 16'h0000;
                  if (last_per) begin
                     pid_active_o <= 1'b1; // see [RULE10]
                     state_reg    <= ST_WAIT;
                  end else begin
                     idx_reg <= idx_reg + 3'h1;
                  end
               end else if (ms_tick_reg) begin
                  elap_reg    <= elap_next;
                  div_num_reg <= ramp_num; // see [RULE9]
                  div_den_reg <= cur.dur_ms;
                  div_go_reg  <= 1'b1;
                  state_reg   <= ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (div_done) begin
                  drive_reg <= 16'(clvcp_wide_t'({1'b0, prev_reg}) + div_q); // see [RULE9]
                  state_reg <= ST_PROF;
               end
            end
            ST_WAIT: begin
               if (dt_tick) begin
                  e_reg       <= err; // see [RULE11]
                  div_num_reg <= clvcp_wide_t'(err) * clvcp_wide_t'(`CLVCP_P_GAIN);
                  div_den_reg <= pid_i.band;
                  div_go_reg  <= 1'b1;
                  state_reg   <= ST_DP;
               end
            end
            ST_DP: begin
               if (div_done) begin
                  p_reg       <= pid_i.band == 16'h0000 ? 40'h00_0000_0000 : div_q; // see [RULE12]
                  div_num_reg <= clvcp_wide_t'(e_reg) * clvcp_wide_t'(`CLVCP_DT_MS);
                  div_den_reg <= pid_i.int_ms;
                  div_go_reg  <= 1'b1;
                  state_reg   <= ST_DI;
               end
            end
            ST_DI: begin
               if (div_done) begin
                  if (pid_i.int_ms == 16'h0000) begin
                     i_reg <= 40'h00_0000_0000; // see [RULE13]
                  end else if (!hold && !wound) begin
                     i_reg <= i_reg + div_q; // see [RULE13] see [RULE15] see [RULE17]
                  end
                  div_num_reg <= d_reg;
                  div_den_reg <= pid_i.der_ms;
                  div_go_reg  <= 1'b1;
                  state_reg   <= ST_DD;
               end
            end
            ST_DD: begin
               if (div_done) begin
                  d_reg     <= pid_i.der_ms == 16'h0000 ? 40'h00_0000_0000
                               : d_reg + clvcp_wide_t'(de) - div_q; // see [RULE14]
                  eprev_reg <= e_reg; // see [RULE14]
                  state_reg <= ST_SUM;
               end
            end
            ST_SUM: begin
               drive_reg <= pid_sat; // see [RULE16]
               state_reg <= ST_WAIT;
            end
            default: begin
               state_reg <= ST_START;
            end
         endcase
      end
   end

   // Output flops
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coil_ma_o   <= 16'h0000;
         fault_o     <= 1'b0;
         freq_hz_o   <= `CLVCP_FRST_HZ;
         freq_rej_o  <= 1'b0;
         src_en_o    <= 6'h00;
         pull_up_o   <= 1'b0;
         pull_down_o <= 1'b0;
      end else begin
         coil_ma_o   <= fault_reg ? 16'h0000 : drive_reg; // see [RULE20]
         fault_o     <= fault_reg;
         freq_rej_o  <= !freq_ok;
         src_en_o    <= src_w;
         pull_up_o   <= bias_up;
         pull_down_o <= bias_dn;
         if (freq_ok) begin
            freq_hz_o <= out_freq_i; // see [RULE18]
         end
      end
   end

   property p_hi_fault;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      hi_trip |=> fault_reg;
   endproperty
   a_hi_fault: assert property (p_hi_fault) else $error("high limit did not fault"); // see [RULE1]

   property p_lo_gate;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !pid_active_o |-> lo_cnt_reg == 16'h0000;
   endproperty
   a_lo_gate: assert property (p_lo_gate) else $error("low timer ran in startup"); // see [RULE2]

   property p_grace;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(fault_reg) |-> $past(hi_cnt_reg) >= $past(lim_i.err_ms) || $past(lo_cnt_reg) >= $past(lim_i.err_ms);
   endproperty
   a_grace: assert property (p_grace) else $error("fault before error time"); // see [RULE3]

   property p_bias;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (pull_up_o || pull_down_o) |-> $past(digi_in) && !(pull_up_o && pull_down_o);
   endproperty
   a_bias: assert property (p_bias) else $error("bias on analog input"); // see [RULE5]

   property p_skip;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_START && all_zero |=> pid_active_o && state_reg == ST_WAIT;
   endproperty
   a_skip: assert property (p_skip) else $error("empty profile not skipped"); // see [RULE7]

   property p_prof_first;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_START && !all_zero |=> !pid_active_o ##1 !pid_active_o;
   endproperty
   a_prof_first: assert property (p_prof_first) else $error("loop before profile"); // see [RULE6]

   property p_kp0;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_DP && div_done && pid_i.band == 16'h0000 |=> p_reg == 40'h00_0000_0000;
   endproperty
   a_kp0: assert property (p_kp0) else $error("band zero term not zero"); // see [RULE12]

   property p_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_DI && div_done && (hold || wound) && pid_i.int_ms != 16'h0000 |=> $stable(i_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("integral moved while held"); // see [RULE17]

   property p_sat;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_SUM |=> drive_reg <= $past(pid_i.windup_ma) ##1 coil_ma_o <= $past(pid_i.windup_ma, 2);
   endproperty
   a_sat: assert property (p_sat) else $error("output above windup guard"); // see [RULE16]

   property p_fault_zero;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      fault_reg |=> coil_ma_o == 16'h0000 && fault_o;
   endproperty
   a_fault_zero: assert property (p_fault_zero) else $error("coil driven in fault"); // see [RULE20]

   property p_freq;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      freq_hz_o >= `CLVCP_FMIN_HZ && freq_hz_o <= `CLVCP_FMAX_HZ;
   endproperty
   a_freq: assert property (p_freq) else $error("drive frequency out of range"); // see [RULE18]

   property p_tick;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == ST_WAIT && dt_tick |=> state_reg == ST_DP ##[40:44] state_reg == ST_DI;
   endproperty
   a_tick: assert property (p_tick) else $error("loop update sequence stalled"); // see [RULE13]

endmodule : clvcp_top

`default_nettype wire

/* File: sim/clvcp_sensor.sv */
`timescale 1ns/100ps
`default_nettype none

module clvcp_sensor (
   input  wire logic        clk_sys_i,
   input  wire logic [15:0] level_i,
   output var  logic [15:0] measured_o
);
   // Updates only on the falling edge, so each reading stands whole cycles for the 2-flop sync
   initial measured_o = 16'h0000;
   always @(negedge clk_sys_i) begin
      measured_o <= level_i;
   end
endmodule : clvcp_sensor

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, b); end end

module tb;
   import clvcp_pkg::*;
   localparam int MS = 200;
   localparam int LIMIT = 80000;
   logic        clk_sys_i;
   logic        rst_n_i;
   logic [15:0] meas_set;
   logic [15:0] meas;
   logic [15:0] out_freq;
   logic [15:0] coil;
   logic [15:0] freq_hz;
   logic [5:0]  src_en;
   logic        fault, pid_on, rej, pull_up, pull_dn;
   clvcp_lim_s  lim;
   clvcp_pid_s  pid;
   clvcp_prof_t prof;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cycles = 0;

   clvcp_sensor i_sensor (.clk_sys_i(clk_sys_i), .level_i(meas_set), .measured_o(meas));

   clvcp_top #(.MS_CYCLES(MS)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .measured_value_i(meas), .lim_i(lim),
      .pid_i(pid), .prof_i(prof), .out_freq_i(out_freq), .coil_ma_o(coil), .fault_o(fault),
      .pid_active_o(pid_on), .freq_hz_o(freq_hz), .freq_rej_o(rej), .src_en_o(src_en),
      .pull_up_o(pull_up), .pull_down_o(pull_dn));

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         test_done();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc

   // Config must be stable from release, so it is set before reset lifts
   task automatic start_run();
      cyc(1);
      rst_n_i = 1'b0;
      cyc(6);
      rst_n_i = 1'b1;
   endtask : start_run

   task automatic set_cfg();
      cyc(1);
      lim = '{3'h0, 2'h1, 16'hFFFF, 16'h0000, 16'h0002};
      pid = '{16'h03E8, 16'h07D0, 16'h0000, 16'h0000, 16'h03E8, 16'h0000};
      prof = '0;
      out_freq = 16'h0096;
      meas_set = 16'h0000;
   endtask : set_cfg

   task automatic wait_coil(input logic [15:0] exp, input int lim_cyc);
      for (int k = 0; k < lim_cyc && coil !== exp; k++) cyc(1);
   endtask : wait_coil

   task automatic t_reset();
      set_cfg();
      rst_n_i = 1'b0;
      cyc(2);
      `CHK({coil, fault, pid_on, freq_hz, rej}, {16'h0000, 1'b0, 1'b0, 16'h0096, 1'b0})
      rst_n_i = 1'b1;
   endtask : t_reset

   task automatic t_freq();
      logic [15:0] fq[4] = '{16'h0027, 16'h0028, 16'h0190, 16'h0191};
      logic [15:0] fx[4] = '{16'h0096, 16'h0028, 16'h0190, 16'h0190};
      for (int i = 0; i < 4; i++) begin
         out_freq = fq[i];
         cyc(2);
         `CHK({freq_hz, rej}, {fx[i], (i == 0 || i == 3)})
      end
      out_freq = 16'h0096;
   endtask : t_freq

   task automatic t_src();
      for (int t = 0; t < 8; t++) begin
         for (int b = 0; b < 3; b++) begin
            lim.in_type = 3'(t);
            lim.bias = 2'(b);
            cyc(2);
            `CHK(src_en, (t < 6) ? 6'(1 << t) : 6'h00)
            `CHK({pull_up, pull_dn}, {(t == 4 || t == 5) && b == 0, (t == 4 || t == 5) && b == 2})
         end
      end
   endtask : t_src

   task automatic t_pid();
      logic [15:0] mv[5] = '{16'h0258, 16'h0258, 16'h0064, 16'h0000, 16'h05DC};
      logic [15:0] bd[5] = '{16'h07D0, 16'h0000, 16'h07D0, 16'h03E8, 16'h07D0};
      logic [15:0] ex[5] = '{16'h0190, 16'h0000, 16'h0384, 16'h03E8, 16'h0000};
      set_cfg();
      start_run();
      cyc(2);
      `CHK(pid_on, 1'b1)
      for (int i = 0; i < 5; i++) begin
         meas_set = mv[i];
         pid.band = bd[i];
         wait_coil(ex[i], 2500);
         `CHK(coil, ex[i])
      end
   endtask : t_pid

   task automatic t_int();
      set_cfg();
      pid = '{16'h03E8, 16'h0000, 16'h0005, 16'h0000, 16'h03E8, 16'h0000};
      meas_set = 16'h0384;
      start_run();
      wait_coil(16'h0064, 2500);
      `CHK(coil, 16'h0064)
      wait_coil(16'h00C8, 1500);
      `CHK(coil, 16'h00C8)
      pid.integral_freeze_threshold = 16'h00C8;
      start_run();
      cyc(3000);
      `CHK(coil, 16'h0000)
      pid = '{16'h03E8, 16'h0000, 16'h0000, 16'h0002, 16'h03E8, 16'h0000};
      start_run();
      wait_coil(16'h0064, 2500);
      `CHK(coil, 16'h0064)
      wait_coil(16'h0032, 1500);
      `CHK(coil, 16'h0032)
   endtask : t_int

   task automatic t_prof();
      set_cfg();
      prof[0] = '{16'h0002, 16'h0064};
      prof[1] = '{16'h0004, 16'h01F4};
      // Empty periods still take their level, so keep it at the last step
      for (int p = 2; p < 6; p++) prof[p] = '{16'h0000, 16'h01F4};
      start_run();
      cyc(MS);
      `CHK({coil, pid_on}, {16'h0064, 1'b0})
      for (int k = 0; k < 3 * MS && coil === 16'h0064; k++) cyc(1);
      `CHK(coil > 16'h0064 && coil < 16'h01F4, 1'b1)
      for (int k = 0; k < 6 * MS && pid_on !== 1'b1; k++) cyc(1);
      `CHK({coil, pid_on}, {16'h01F4, 1'b1})
   endtask : t_prof

   task automatic t_fault();
      set_cfg();
      pid.target_value = 16'h0BB8;
      lim.max_lim = 16'h03E8;
      meas_set = 16'h0258;
      start_run();
      wait_coil(16'h03E8, 2500);
      meas_set = 16'h05DC;
      cyc(MS / 2);
      meas_set = 16'h0258;
      cyc(4 * MS);
      `CHK(fault, 1'b0)
      meas_set = 16'h05DC;
      for (int k = 0; k < 4 * MS && fault !== 1'b1; k++) cyc(1);
      `CHK(fault, 1'b1)
      meas_set = 16'h0258;
      cyc(2 * MS);
      `CHK({coil, fault}, {16'h0000, 1'b1})
   endtask : t_fault

   task automatic t_min();
      set_cfg();
      prof[0] = '{16'h0005, 16'h00C8};
      lim.min_lim = 16'h0064;
      lim.err_ms = 16'h0001;
      meas_set = 16'h0032;
      start_run();
      cyc(4 * MS);
      `CHK({fault, pid_on}, 2'b00)
      for (int k = 0; k < 3 * MS && pid_on !== 1'b1; k++) cyc(1);
      for (int k = 0; k < 4 * MS && fault !== 1'b1; k++) cyc(1);
      `CHK(fault, 1'b1)
   endtask : t_min

   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   initial begin
      rst_n_i = 1'b0;
      lim = '0;
      pid = '0;
      prof = '0;
      out_freq = 16'h0096;
      meas_set = 16'h0000;
      t_reset();
      t_freq();
      t_src();
      t_pid();
      t_int();
      t_prof();
      t_fault();
      t_min();
      test_done();
   end
endmodule : tb

`default_nettype wire
